/* File: inc/sfc_pkg.sv */
// constants shared by both ends of the flash instruction link
package sfc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam logic [7:0] OP_ERASE_ALL_A = 8'h00_C7;
  localparam logic [7:0] OP_ERASE_ALL_B = 8'h00_60;
  localparam logic [7:0] OP_SUSPEND     = 8'h00_75;
  localparam logic [7:0] OP_RESUME      = 8'h00_7A;
  localparam logic [7:0] OP_POWERDOWN   = 8'h00_B9;
  localparam logic [7:0] OP_RELEASE_ID  = 8'h00_AB;
  localparam logic [7:0] OP_MFR_DEV_ID  = 8'h00_90;
  localparam logic [7:0] OP_WRITE_EN    = 8'h00_06;
  localparam logic [7:0] OP_READ_STATUS = 8'h00_05;
  localparam logic [7:0] OP_WRITE_STAT  = 8'h00_01;
  localparam logic [7:0] OP_SECT_ERASE  = 8'h00_20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h00_52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'h00_D8;
  localparam logic [7:0] OP_SECREG_ERASE = 8'h00_44;
  localparam logic [7:0] OP_PAGE_PROG   = 8'h00_02;
  localparam logic [7:0] OP_QPAGE_PROG  = 8'h00_32;
  localparam logic [7:0] OP_SECREG_PROG = 8'h00_42;
  localparam logic [7:0] ERASED_BYTE    = 8'h00_FF;
  localparam int unsigned ID_DUMMY_BYTES   = 3;
  localparam int unsigned MFR_ADDR_BYTES   = 3;
  localparam logic [23:0] MFR_ADDR_VALUE   = 24'h00_0000;
  // status bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_WEL  = 1;
  localparam int unsigned ST_SUS  = 7;
  // resume-to-busy latency, ns
  localparam int unsigned RESUME_BUSY_NS = 200;
  localparam int unsigned RESUME_BUSY_CYC =
    (RESUME_BUSY_NS / CLK_PERIOD_NS) < 1 ? 1 :
    RESUME_BUSY_NS / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    SFC_OP_NONE    = 4'b0001,
    SFC_OP_ERASE   = 4'b0010,
    SFC_OP_PROGRAM = 4'b0100,
    SFC_OP_CHIP    = 4'b1000
  } sfc_op_t;
endpackage : sfc_pkg

/* File: inc/sfc_link_if.sv */
// serial link between flash controller and flash device
`timescale 1ns/1ps
interface sfc_link_if;
  logic cs_n;
  logic sclk;
  logic serial_input;
  logic sout;
  logic sout_oe;
  modport device (input cs_n, input sclk, input serial_input,
                  output sout, output sout_oe);
  modport host (output cs_n, output sclk, output serial_input,
                input sout, input sout_oe);
endinterface : sfc_link_if

/* File: src/sfc_host.sv */
// host end: shifts one instruction frame out and collects reply bytes
`timescale 1ns/1ps
module sfc_host
  import sfc_pkg::*;
#(
  parameter int unsigned DIV = 4
)(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  sfc_link_if.host        link,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [7:0] req_opcode,
  input  wire logic [2:0] req_tx_bytes,
  input  wire logic [23:0] req_tx_data,
  input  wire logic [2:0] req_rx_bytes,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            done
);
  initial if (DIV < 2 || DIV % 2 != 0) $error("DIV must be even, >= 2");

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SHIFT = 3'b010,
    HS_END  = 3'b100
  } sfc_hst_t;
  sfc_hst_t state_reg;

  logic [15:0] div_reg;
  logic        sclk_reg;
  logic [31:0] tx_reg;
  logic [5:0]  tx_left_reg;
  logic [5:0]  rx_left_reg;
  logic [7:0]  rx_sh_reg;
  logic [2:0]  rx_cnt_reg;
  logic [1:0]  sin_sync_reg;
  logic        rise;
  logic        fall;

  assign req_ready = (state_reg == HS_IDLE);
  assign rise = (state_reg == HS_SHIFT) && !sclk_reg
                && div_reg == 16'(DIV / 2 - 1);
  assign fall = (state_reg == HS_SHIFT) && sclk_reg
                && div_reg == 16'(DIV / 2 - 1);
  assign link.sclk = sclk_reg;
  assign link.cs_n = (state_reg != HS_SHIFT);
  // msb first, valid before each rising edge
  assign link.serial_input = tx_reg[31];

  // data sync: the device answers a few clocks after our falling edge, so
  // the reply bit is taken at the next falling edge, a full period later
  always_ff @(posedge clk)
    sin_sync_reg <= sys_rst ? 2'b00 : {sin_sync_reg[0], link.sout};

  // divider for the serial clock
  always_ff @(posedge clk)
    if (sys_rst || state_reg != HS_SHIFT) div_reg <= '0;
    else if (div_reg == 16'(DIV / 2 - 1)) div_reg <= '0;
    else div_reg <= div_reg + 16'd1;

  // frame sequencer; cs rises right after the last bit
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      state_reg <= HS_IDLE;
      sclk_reg <= 1'b0;
      tx_reg <= '0;
      tx_left_reg <= '0;
      rx_left_reg <= '0;
      rx_sh_reg <= '0;
      rx_cnt_reg <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      done <= 1'b0;
      unique case (state_reg)
        HS_IDLE:
          if (req_valid)
          begin
            // address of the id read is forced to zero
            tx_reg <= {req_opcode,
                       req_opcode == OP_MFR_DEV_ID ? MFR_ADDR_VALUE
                                                   : req_tx_data};
            tx_left_reg <= 6'({req_tx_bytes, 3'b000}) + 6'd8;
            rx_left_reg <= 6'({req_rx_bytes, 3'b000});
            rx_cnt_reg <= '0;
            state_reg <= HS_SHIFT;
          end
        HS_SHIFT:
        begin
          if (rise) sclk_reg <= 1'b1;
          if (fall)
          begin
            sclk_reg <= 1'b0;
            if (tx_left_reg != 0)
            begin
              tx_reg <= {tx_reg[30:0], 1'b0};
              tx_left_reg <= tx_left_reg - 6'd1;
            end
            else if (rx_left_reg != 0)
              rx_left_reg <= rx_left_reg - 6'd1;
            if ((tx_left_reg == 1 && rx_left_reg == 0) ||
                (tx_left_reg == 0 && rx_left_reg == 1))
              state_reg <= HS_END;
          end
          if (fall && tx_left_reg == 0 && rx_left_reg != 0)
          begin
            rx_sh_reg <= {rx_sh_reg[6:0], sin_sync_reg[1]};
            rx_cnt_reg <= rx_cnt_reg + 3'd1;
            if (rx_cnt_reg == 3'd7)
            begin
              rx_data <= {rx_sh_reg[6:0], sin_sync_reg[1]};
              rx_valid <= 1'b1;
            end
          end
        end
        HS_END:
        begin
          done <= 1'b1;
          state_reg <= HS_IDLE;
        end
      endcase
    end
endmodule : sfc_host

/* File: src/sfc_device.sv */
// device end: instruction decoder for erase, suspend, power-down and ids
// Contract
// - C7h or 60h erases whole array
// - whole erase needs write enable latch
// - chip select rises on byte boundary
// - busy high during erase, status readable
// - whole erase end clears write enable
// - any protection blocks whole erase
// - suspend accepted only busy, unsuspended, suspendable
// - suspend ignored during whole erase
// - erase suspended rejects status write, erases
// - program suspended rejects status write, programs
// - suspend sets flag, busy drops within latency
// - host waits latency between resume, suspend
// - reset clears suspend flag, pending operation
// - resume only suspended idle; busy within 200ns
// - B9h enters power-down after entry latency
// - power-down honours only release opcode
// - powers up in normal operation
// - release waits first latency, cs high
// - three dummies then repeating device id
// - id release waits second latency
// - release or id ignored while busy
// - 90h with address gives alternating ids
`timescale 1ns/1ps
module sfc_device
  import sfc_pkg::*;
#(
  parameter logic [7:0]  MFR_ID          = 8'h00_5A, // arbitrary value
  parameter logic [7:0]  DEV_ID          = 8'h00_11, // arbitrary value
  parameter int unsigned ERASE_ALL_CYC   = 20000,
  parameter int unsigned ERASE_CYC       = 8000,
  parameter int unsigned PROG_CYC        = 4000,
  parameter int unsigned SUSPEND_CYC     = 20,
  parameter int unsigned PD_ENTRY_CYC    = 60,
  parameter int unsigned RELEASE1_CYC    = 60,
  parameter int unsigned RELEASE2_CYC    = 60
)(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  sfc_link_if.device      link,
  input  wire logic [5:0] protect_bits,
  input  wire logic       start_erase,
  input  wire logic       start_program,
  output logic            busy,
  output logic            write_enable_latch,
  output logic            suspend_flag,
  output logic            powered_down,
  output logic            array_erase_pulse
);
  initial if (SUSPEND_CYC < 1 || ERASE_ALL_CYC >= 2 ** 24)
    $error("timing parameters out of range");

  // link pins pass two flops before use
  logic [1:0] cs_s_reg;
  logic [1:0] ck_s_reg;
  logic [1:0] si_s_reg;
  logic       ck_d_reg;
  logic       cs_d_reg;
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      cs_s_reg <= 2'b11;
      ck_s_reg <= 2'b00;
      si_s_reg <= 2'b00;
      ck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end
    else
    begin
      cs_s_reg <= {cs_s_reg[0], link.cs_n};
      ck_s_reg <= {ck_s_reg[0], link.sclk};
      si_s_reg <= {si_s_reg[0], link.serial_input};
      ck_d_reg <= ck_s_reg[1];
      cs_d_reg <= cs_s_reg[1];
    end

  logic ck_rise;
  logic ck_fall;
  logic cs_rise;
  logic sel;
  assign sel = !cs_s_reg[1];
  assign ck_rise = sel && ck_s_reg[1] && !ck_d_reg;
  assign ck_fall = sel && !ck_s_reg[1] && ck_d_reg;
  assign cs_rise = cs_s_reg[1] && !cs_d_reg;

  // bit collector, msb first on rising edges
  logic [7:0]  shift_reg;
  logic [15:0] bitcnt_reg;
  logic [7:0]  opcode_reg;
  logic [23:0] addr_reg;
  always_ff @(posedge clk)
    if (sys_rst || !sel)
    begin
      shift_reg <= '0;
      bitcnt_reg <= '0;
      opcode_reg <= '0;
      addr_reg <= '0;
    end
    else if (ck_rise)
    begin
      shift_reg <= {shift_reg[6:0], si_s_reg[1]};
      bitcnt_reg <= bitcnt_reg + 16'd1;
      if (bitcnt_reg == 16'd7)
        opcode_reg <= {shift_reg[6:0], si_s_reg[1]};
      else if (bitcnt_reg < 16'd32)
        addr_reg <= {addr_reg[22:0], si_s_reg[1]};
    end

  // operation and timing state
  sfc_op_t     op_reg;
  sfc_op_t     susp_op_reg;
  logic [23:0] timer_reg;
  logic [23:0] remain_reg;
  logic [7:0]  lat_reg;
  logic        susp_pend_reg;
  logic        res_pend_reg;
  logic [15:0] pd_cnt_reg;
  logic        pd_entering_reg;
  logic        releasing_reg;

  // frame end decode happens at cs rise, exactly one byte for commands
  logic one_byte;
  logic erase_blocked;
  logic prog_blocked;
  logic accept;
  assign one_byte = cs_rise && bitcnt_reg == 16'd8;
  assign erase_blocked = suspend_flag && susp_op_reg == SFC_OP_ERASE;
  assign prog_blocked  = suspend_flag && susp_op_reg == SFC_OP_PROGRAM;
  // no command but release taken while powered down or waking
  assign accept = !powered_down && !releasing_reg && !pd_entering_reg;

  logic do_chip;
  assign do_chip = accept && one_byte && !busy && write_enable_latch
    && (opcode_reg == OP_ERASE_ALL_A || opcode_reg == OP_ERASE_ALL_B)
    && protect_bits == 6'b00_0000
    && !erase_blocked;

  logic do_susp;
  assign do_susp = accept && one_byte && opcode_reg == OP_SUSPEND
    && !suspend_flag && busy && !susp_pend_reg
    && op_reg != SFC_OP_CHIP && op_reg != SFC_OP_NONE;

  logic do_res;
  assign do_res = accept && one_byte && opcode_reg == OP_RESUME
    && suspend_flag && !busy;

  logic do_start_e;
  logic do_start_p;
  assign do_start_e = start_erase && accept && !busy && write_enable_latch
    && !erase_blocked;
  assign do_start_p = start_program && accept && !busy
    && write_enable_latch && !prog_blocked;

  // write enable latch; cleared when a self-timed cycle completes
  logic op_finish;
  assign op_finish = busy && !susp_pend_reg && op_reg != SFC_OP_NONE
    && timer_reg == 24'd1;
  always_ff @(posedge clk)
    if (sys_rst) write_enable_latch <= 1'b0;
    else if (op_finish) write_enable_latch <= 1'b0;
    else if (accept && one_byte && !busy && opcode_reg == OP_WRITE_EN)
      write_enable_latch <= 1'b1;

  // self-timed engine with suspend and resume; reset drops all
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      op_reg <= SFC_OP_NONE;
      susp_op_reg <= SFC_OP_NONE;
      busy <= 1'b0;
      suspend_flag <= 1'b0;
      timer_reg <= '0;
      remain_reg <= '0;
      lat_reg <= '0;
      susp_pend_reg <= 1'b0;
      res_pend_reg <= 1'b0;
      array_erase_pulse <= 1'b0;
    end
    else
    begin
      array_erase_pulse <= 1'b0;
      if (do_chip)
      begin
        op_reg <= SFC_OP_CHIP;
        busy <= 1'b1;
        timer_reg <= 24'(ERASE_ALL_CYC);
      end
      else if (do_start_e || do_start_p)
      begin
        op_reg <= do_start_e ? SFC_OP_ERASE : SFC_OP_PROGRAM;
        busy <= 1'b1;
        timer_reg <= do_start_e ? 24'(ERASE_CYC) : 24'(PROG_CYC);
      end
      else if (do_susp)
      begin
        suspend_flag <= 1'b1;
        susp_pend_reg <= 1'b1;
        remain_reg <= timer_reg;
        susp_op_reg <= op_reg;
        lat_reg <= 8'(SUSPEND_CYC);
      end
      else if (susp_pend_reg)
      begin
        if (lat_reg <= 8'd1)
        begin
          busy <= 1'b0;
          op_reg <= SFC_OP_NONE;
          susp_pend_reg <= 1'b0;
        end
        lat_reg <= lat_reg - 8'd1;
      end
      else if (do_res)
      begin
        suspend_flag <= 1'b0;
        res_pend_reg <= 1'b1;
        lat_reg <= 8'(RESUME_BUSY_CYC);
      end
      else if (res_pend_reg)
      begin
        if (lat_reg <= 8'd1)
        begin
          busy <= 1'b1;
          op_reg <= susp_op_reg;
          timer_reg <= remain_reg;
          susp_op_reg <= SFC_OP_NONE;
          res_pend_reg <= 1'b0;
        end
        lat_reg <= lat_reg - 8'd1;
      end
      else if (busy && op_reg != SFC_OP_NONE)
      begin
        timer_reg <= timer_reg - 24'd1;
        if (op_finish)
        begin
          busy <= 1'b0;
          if (op_reg == SFC_OP_CHIP) array_erase_pulse <= 1'b1;
          op_reg <= SFC_OP_NONE;
        end
      end
    end

  // power-down entry and release; starts normal after reset
  logic release_plain;
  logic release_id;
  assign release_plain = one_byte && opcode_reg == OP_RELEASE_ID;
  assign release_id = cs_rise && opcode_reg == OP_RELEASE_ID
    && bitcnt_reg >= 16'(8 * (ID_DUMMY_BYTES + 1));
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      powered_down <= 1'b0;
      pd_entering_reg <= 1'b0;
      releasing_reg <= 1'b0;
      pd_cnt_reg <= '0;
    end
    else if (pd_entering_reg || releasing_reg)
    begin
      pd_cnt_reg <= pd_cnt_reg - 16'd1;
      if (pd_cnt_reg <= 16'd1)
      begin
        if (pd_entering_reg) powered_down <= 1'b1;
        pd_entering_reg <= 1'b0;
        releasing_reg <= 1'b0;
      end
    end
    else if (accept && one_byte && opcode_reg == OP_POWERDOWN && !busy)
    begin
      pd_entering_reg <= 1'b1;
      pd_cnt_reg <= 16'(PD_ENTRY_CYC);
    end
    else if (powered_down && !busy && (release_plain || release_id))
    begin
      powered_down <= 1'b0;
      releasing_reg <= 1'b1;
      pd_cnt_reg <= release_id ? 16'(RELEASE2_CYC)
                               : 16'(RELEASE1_CYC);
    end

  // reply shifter: status, device id or alternating ids on falling edges
  logic [7:0] out_reg;
  logic       oe_reg;
  logic       id_sel_reg;
  logic [7:0] status_byte;
  assign status_byte = 8'((busy ? 1 : 0) << ST_BUSY)
    | 8'((write_enable_latch ? 1 : 0) << ST_WEL)
    | 8'((suspend_flag ? 1 : 0) << ST_SUS);
  always_ff @(posedge clk)
    if (sys_rst || !sel)
    begin
      out_reg <= '0;
      oe_reg <= 1'b0;
      id_sel_reg <= 1'b0;
    end
    else if (ck_fall && bitcnt_reg[2:0] == 3'd0 && bitcnt_reg != 16'd0)
    begin
      oe_reg <= 1'b0;
      if (!powered_down && !releasing_reg && !pd_entering_reg)
      begin
        if (opcode_reg == OP_READ_STATUS)
        begin
          out_reg <= status_byte;
          oe_reg <= 1'b1;
        end
        else if (opcode_reg == OP_RELEASE_ID && !busy
                 && bitcnt_reg >= 16'(8 * (ID_DUMMY_BYTES + 1)))
        begin
          out_reg <= DEV_ID;
          oe_reg <= 1'b1;
        end
        else if (opcode_reg == OP_MFR_DEV_ID
                 && bitcnt_reg >= 16'(8 * (MFR_ADDR_BYTES + 1)))
        begin
          out_reg <= id_sel_reg ? DEV_ID : MFR_ID;
          id_sel_reg <= !id_sel_reg;
          oe_reg <= 1'b1;
        end
      end
      else if (opcode_reg == OP_RELEASE_ID && !busy
               && bitcnt_reg >= 16'(8 * (ID_DUMMY_BYTES + 1)))
      begin
        out_reg <= DEV_ID;
        oe_reg <= 1'b1;
      end
    end
    else if (ck_fall && oe_reg)
      out_reg <= {out_reg[6:0], out_reg[7]}; // msb first, repeats

  assign link.sout = out_reg[7];
  assign link.sout_oe = oe_reg;
endmodule : sfc_device

/* File: test/sfc_link_monitor.sv */
// concurrent checks on the flash link wires and the device status flags
`timescale 1ns/1ps
module sfc_link_monitor #(
  parameter int SUS_MAX = 14
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_input,
  input wire logic sout,
  input wire logic sout_oe,
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic suspend_flag,
  input wire logic powered_down,
  input wire logic array_erase_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // the device may only drive its output inside a frame
  a_idle_no_drive: assert property (cs_n [*8] |-> !sout_oe)
    else $error("device drives output outside a frame");
  a_erase_wel_clear: assert property (
    array_erase_pulse |=> !write_enable_latch)
    else $error("write enable kept after whole erase");
  a_erase_busy_end: assert property (
    array_erase_pulse |-> ##[0:1] !busy)
    else $error("busy held after whole erase finished");
  a_suspend_drop: assert property (
    $rose(suspend_flag) |-> ##[0:SUS_MAX] !busy)
    else $error("busy not cleared within suspend latency");
  // a suspend is only taken while an operation runs
  a_suspend_cause: assert property (
    $rose(suspend_flag) |-> $past(busy))
    else $error("suspend taken while idle");
  // 200 ns is four cycles of the 50 ns clock
  a_resume_busy: assert property (
    $fell(suspend_flag) |-> ##[0:4] busy)
    else $error("busy not set after resume");
  a_pd_holds: assert property (
    $rose(powered_down) |=> powered_down [*4])
    else $error("power-down state left too soon");
  a_reset_normal: assert property (
    $fell(sys_rst) |-> !powered_down && !suspend_flag)
    else $error("device not in normal state after reset");
endmodule : sfc_link_monitor

/* File: test/testbench.sv */
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module testbench;
  import sfc_pkg::*;
  localparam logic [7:0] MFR = 8'h00_3C; // arbitrary value
  localparam logic [7:0] DEV = 8'h00_4D; // arbitrary value
  typedef struct {
    logic [7:0] op;
    logic [2:0] txb;
    logic [2:0] rxb;
    logic [7:0] e0;
    logic [7:0] e1;
  } sfc_row_t;
  logic clk, sys_rst, req_valid, req_ready, rx_valid, done;
  logic [7:0] req_opcode, rx_data;
  logic [2:0] req_tx_bytes, req_rx_bytes;
  logic [23:0] req_tx_data;
  logic [5:0] protect_bits;
  logic start_erase, start_program, busy, write_enable_latch;
  logic suspend_flag, powered_down, array_erase_pulse;
  int fails, n_tests, cyc;
  logic [7:0] rxq[$];
  sfc_row_t rows[5];

  sfc_link_if link();
  sfc_host #(.DIV(8)) u_sfc_host (.clk, .sys_rst, .link(link), .req_valid,
    .req_ready, .req_opcode, .req_tx_bytes, .req_tx_data, .req_rx_bytes,
    .rx_data, .rx_valid, .done);
  sfc_device #(.MFR_ID(MFR), .DEV_ID(DEV), .ERASE_ALL_CYC(3000),
    .ERASE_CYC(3000), .PROG_CYC(3000))
  u_sfc_device (.clk, .sys_rst, .link(link), .protect_bits, .start_erase,
    .start_program, .busy, .write_enable_latch, .suspend_flag,
    .powered_down, .array_erase_pulse);
  sfc_link_monitor #(.SUS_MAX(24)) u_mon (.clk, .sys_rst,
    .cs_n(link.cs_n), .sclk(link.sclk), .serial_input(link.serial_input),
    .sout(link.sout), .sout_oe(link.sout_oe), .busy, .write_enable_latch,
    .suspend_flag, .powered_down, .array_erase_pulse);

  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // cut a hang short well past the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails = fails + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one whole frame; request held until the edge that takes it
  task automatic xfer(input logic [7:0] op, input logic [2:0] txb,
                      input logic [2:0] rxb);
    int i;
    rxq = {};
    @(negedge clk);
    req_opcode = op;
    req_tx_bytes = txb;
    req_tx_data = MFR_ADDR_VALUE;
    req_rx_bytes = rxb;
    req_valid = 1;
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    req_valid = 0;
    for (i = 0; i < 3000 && done !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
    end
    // device decodes a few cycles after chip select rises
    repeat (8) @(negedge clk);
  endtask : xfer

  task automatic wait_on(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(negedge clk);
  endtask : wait_on

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask : pulse

  task automatic do_reset();
    sys_rst = 1;
    repeat (4) @(negedge clk);
    sys_rst = 0;
  endtask : do_reset

  initial
  begin
    {req_valid, start_erase, start_program, cyc, fails, n_tests} = '0;
    {req_opcode, req_tx_bytes, req_tx_data, req_rx_bytes} = '0;
    protect_bits = '0;
    rows = '{'{OP_READ_STATUS, 0, 1, 8'h00_00, 8'h00_00},
             '{OP_WRITE_EN, 0, 0, 8'h00_00, 8'h00_00},
             '{OP_READ_STATUS, 0, 1, 8'h00_02, 8'h00_00},
             '{OP_MFR_DEV_ID, 3, 4, MFR, DEV},
             '{OP_RELEASE_ID, 3, 3, DEV, DEV}};
    do_reset();
    chk("powered_down", 0, powered_down);
    xfer(OP_ERASE_ALL_A, 0, 0);
    chk("busy no wel", 0, busy);
    foreach (rows[r])
    begin
      xfer(rows[r].op, rows[r].txb, rows[r].rxb);
      for (int k = 0; k < rows[r].rxb; k++)
        chk("row byte", k % 2 ? rows[r].e1 : rows[r].e0, rxq[k]);
    end
    // protection active, then a frame one byte too long
    protect_bits = 6'h01;
    xfer(OP_ERASE_ALL_A, 0, 0);
    chk("busy protected", 0, busy);
    protect_bits = 6'h00;
    xfer(OP_WRITE_EN, 0, 0);
    xfer(OP_ERASE_ALL_B, 1, 0);
    chk("busy long frame", 0, busy);
    foreach (rows[r])
    begin
      if (r > 1) break;
      xfer(OP_WRITE_EN, 0, 0);
      xfer(r ? OP_ERASE_ALL_B : OP_ERASE_ALL_A, 0, 0);
      chk("busy erase", 1, busy);
      xfer(OP_READ_STATUS, 0, 1);
      chk("status busy", 1, rxq[0][ST_BUSY]);
      xfer(OP_SUSPEND, 0, 0);
      chk("suspend in erase", 0, suspend_flag);
      xfer(OP_RELEASE_ID, 3, 1);
      chk("busy after id", 1, busy);
      wait_on(array_erase_pulse, 1, 4000);
      @(negedge clk);
      chk("wel end", 0, write_enable_latch);
      chk("busy end", 0, busy);
    end
    // sector erase stand-in suspended, refused, resumed
    xfer(OP_WRITE_EN, 0, 0);
    pulse(start_erase);
    xfer(OP_SUSPEND, 0, 0);
    chk("suspend set", 1, suspend_flag);
    wait_on(busy, 0, 30);
    chk("busy suspended", 0, busy);
    xfer(OP_WRITE_EN, 0, 0);
    xfer(OP_ERASE_ALL_A, 0, 0);
    chk("erase refused", 0, busy);
    xfer(OP_SECT_ERASE, 3, 0);
    chk("sector refused", 0, busy);
    xfer(OP_RESUME, 0, 0);
    chk("suspend cleared", 0, suspend_flag);
    chk("busy resumed", 1, busy);
    // a fresh suspend only after the suspend latency has passed
    repeat (30) @(negedge clk);
    xfer(OP_SUSPEND, 0, 0);
    chk("suspend again", 1, suspend_flag);
    wait_on(busy, 0, 30);
    xfer(OP_RESUME, 0, 0);
    chk("resume again", 0, suspend_flag);
    wait_on(busy, 0, 4000);
    // program suspended, then reset while suspended
    xfer(OP_WRITE_EN, 0, 0);
    pulse(start_program);
    xfer(OP_SUSPEND, 0, 0);
    xfer(OP_WRITE_EN, 0, 0);
    xfer(OP_PAGE_PROG, 3, 0);
    chk("program refused", 0, busy);
    do_reset();
    chk("suspend after reset", 0, suspend_flag);
    xfer(OP_RESUME, 0, 0);
    chk("resume ignored", 0, busy);
    // power-down entry, ignored command, plain and id release
    xfer(OP_POWERDOWN, 0, 0);
    wait_on(powered_down, 1, 100);
    chk("pd entered", 1, powered_down);
    xfer(OP_WRITE_EN, 0, 0);
    chk("wel in pd", 0, write_enable_latch);
    xfer(OP_RELEASE_ID, 0, 0);
    wait_on(powered_down, 0, 100);
    repeat (80) @(negedge clk);
    chk("pd released", 0, powered_down);
    xfer(OP_POWERDOWN, 0, 0);
    wait_on(powered_down, 1, 100);
    xfer(OP_RELEASE_ID, 3, 1);
    chk("release id", DEV, rxq[0]);
    wait_on(powered_down, 0, 100);
    chk("pd released id", 0, powered_down);
    test_done();
  end
endmodule : testbench
